// *** hdl/crc_byte_step.sv ***
// One bytewise CRC update, MSB first, 16- or 32-bit wide
`timescale 1ns/1ns
`default_nettype none
`include "crc_engine_map.svh"
module crc_byte_step
  import crc_engine_pkg::*;
(
  input wire logic [31:0] crc,
  input wire logic [7:0] data_byte,
  input wire logic [31:0] poly,
  input wire logic wide,
  output logic [31:0] next_crc
);
  always_comb begin
    logic [31:0] c;
    c = crc;
    if (wide) begin
      c[31:24] = c[31:24] ^ data_byte;
      for (int i = 0; i < `BYTE_STEPS; i++) begin
        c = c[31] ? ({c[30:0], 1'b0} ^ poly) : {c[30:0], 1'b0};
      end
    end else begin
      c[31:16] = 16'h0000;
      c[15:8] = c[15:8] ^ data_byte;
      for (int i = 0; i < `BYTE_STEPS; i++) begin
        c[15:0] = c[15] ? ({c[14:0], 1'b0} ^ poly[15:0]) : {c[14:0], 1'b0};
      end
    end
    next_crc = c;
  end
endmodule // crc_byte_step
`default_nettype wire

// *** hdl/crc_engine_map.svh ***
// Field positions, reset values and sizes of the CRC engine
`ifndef CRC_ENGINE_MAP_SVH
`define CRC_ENGINE_MAP_SVH

`define CTRL_WRITE_TRANSPOSE_HI 31
`define CTRL_WRITE_TRANSPOSE_LO 30
`define CTRL_READ_TRANSPOSE_HI 29
`define CTRL_READ_TRANSPOSE_LO 28
`define CTRL_READ_COMPLEMENT_BIT 26
`define CTRL_SEED_WRITE_BIT 25
`define CTRL_WIDTH_SELECT_BIT 24
`define CTRL_WRITABLE_MASK 32'hf700_0000
`define CTRL_RESET 32'h0000_0000
`define POLY_RESET 32'h0000_1021
`define CRC_RESET 32'h0000_0000
`define FIFO_DEPTH_DEFAULT 16
`define BYTE_STEPS 8

`endif

// *** hdl/crc_engine_pkg.sv ***
// Types shared by the CRC engine modules
package crc_engine_pkg;

  typedef enum logic [1:0] {
    TRANSPOSE_NONE = 2'h0,
    TRANSPOSE_BITS = 2'h1,
    TRANSPOSE_BOTH = 2'h2,
    TRANSPOSE_BYTES = 2'h3
  } transpose_type;

  typedef enum logic [1:0] {
    SIZE_8 = 2'h0,
    SIZE_16 = 2'h1,
    SIZE_32 = 2'h2
  } access_size_type;

  // One queued write: seed word as transposed, or message bytes aligned to the top of the word
  typedef struct packed {
    logic seed;
    logic [2:0] nbytes;
    logic [31:0] word;
  } fifo_entry_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_FETCH = 4'h2,
    ST_LATCH = 4'h4,
    ST_UPDATE = 4'h8
  } engine_state_type;

endpackage

// *** hdl/crc_engine_with_transpose.sv ***
// Programmable CRC engine with write and read transposition
//
// Function
// - Seed select makes data writes load seed
// - Seed write fully reinitialises the checksum
// - 8, 16, 32-bit writes; bytes contiguous
// - Width select: 0 is 16-bit, 1 is 32-bit
// - 16-bit mode uses lower polynomial half only
// - 16-bit seed from lower two bytes
// - 32-bit mode uses full polynomial and seed
// - Data writes update checksum at mode width
// - Bytewise processing, two clocks per byte
// - Independent write and read transposition
// - Transpose off by default; 00 passes
// - 01 reverses bits within each byte
// - 10 reverses the whole 32-bit word
// - 11 reverses byte order only
// - Short writes zero-padded, CRC on valid bytes
// - 16-bit result moves high under 10/11
// - Complement bit inverts every data read
// - Complement clear returns raw checksum
// - Seed select at control bit 25
// - Write transpose 31:30, read transpose 29:28
// - Read complement at control bit 26
// - Upper polynomial half frozen in 16-bit
`timescale 1ns/1ns
`default_nettype none
`include "crc_engine_map.svh"
module crc_engine_with_transpose
  import crc_engine_pkg::*;
#(
  parameter int FIFO_DEPTH = `FIFO_DEPTH_DEFAULT
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ctrl_wr,
  input wire logic [31:0] ctrl_wdata,
  output logic [31:0] ctrl_rdata,
  input wire logic poly_wr,
  input wire logic [31:0] poly_wdata,
  output logic [31:0] poly_rdata,
  input wire logic data_wr,
  input wire logic [1:0] data_size,
  input wire logic [31:0] data_wdata,
  output logic data_ready,
  output logic [31:0] data_rdata,
  output logic busy
);
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("FIFO_DEPTH must be at least 2");
  end

  function automatic logic [31:0] transpose(input logic [31:0] w, input logic [1:0] kind);
    logic [31:0] bits_rev;
    logic [31:0] bytes_rev;
    for (int i = 0; i < 32; i++) bits_rev[i] = w[(i & ~7) + 7 - (i & 7)];
    for (int i = 0; i < 32; i++) bytes_rev[i] = w[24 - (i & ~7) + (i & 7)];
    unique case (transpose_type'(kind))
      TRANSPOSE_NONE: transpose = w;
      TRANSPOSE_BITS: transpose = bits_rev;
      TRANSPOSE_BOTH: transpose = {<<{w}};
      TRANSPOSE_BYTES: transpose = bytes_rev;
    endcase
  endfunction

  logic [31:0] ctrl;
  logic [31:0] poly;
  logic [31:0] crc;
  engine_state_type state;
  logic [31:0] word_sh;
  logic [2:0] left;
  logic [7:0] cur_byte;

  // Control fields
  // transpose field slices
  wire [1:0] write_transpose_type = ctrl[`CTRL_WRITE_TRANSPOSE_HI:`CTRL_WRITE_TRANSPOSE_LO];
  wire [1:0] read_transpose_type = ctrl[`CTRL_READ_TRANSPOSE_HI:`CTRL_READ_TRANSPOSE_LO];
  wire read_complement_enable = ctrl[`CTRL_READ_COMPLEMENT_BIT];
  wire seed_write_select = ctrl[`CTRL_SEED_WRITE_BIT];
  wire crc_width_select = ctrl[`CTRL_WIDTH_SELECT_BIT];

  // Write path: pad, transpose on the fly, then align valid bytes to the top
  // size decode for 8/16/32
  wire [2:0] in_nbytes = (data_size == SIZE_8) ? 3'd1 : (data_size == SIZE_16) ? 3'd2 : 3'd4;
  wire [31:0] in_masked = (data_size == SIZE_8) ? {24'h000000, data_wdata[7:0]} :
                          (data_size == SIZE_16) ? {16'h0000, data_wdata[15:0]} : data_wdata;
  wire [31:0] in_tr = transpose(in_masked, write_transpose_type);
  // byte-moving types already place valid bytes high
  wire [5:0] align_shift = write_transpose_type[1] ? 6'd0 : 6'((3'd4 - in_nbytes) * 8);
  wire [31:0] in_aligned = in_tr << align_shift;

  fifo_entry_type in_entry;
  fifo_entry_type out_entry;
  logic [$bits(fifo_entry_type)-1:0] out_bits;
  logic fifo_in_ready;
  logic fifo_out_valid;
  // seed flag chosen at write time, keeping order with data
  assign in_entry.seed = seed_write_select;
  assign in_entry.nbytes = in_nbytes;
  assign in_entry.word = seed_write_select ? in_tr : in_aligned;
  assign out_entry = fifo_entry_type'(out_bits);
  wire pop = (state == ST_IDLE) && fifo_out_valid;

  crc_fifo #(
    .WIDTH($bits(fifo_entry_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(data_wr),
    .in_ready(fifo_in_ready),
    .in_data(in_entry),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(out_bits)
  );
  assign data_ready = fifo_in_ready;

  // narrow mode sees only the low polynomial half
  wire [31:0] poly_used = crc_width_select ? poly : {16'h0000, poly[15:0]};
  logic [31:0] step_crc;

  crc_byte_step u_step (
    .crc(crc),
    .data_byte(cur_byte),
    .poly(poly_used),
    .wide(crc_width_select),
    .next_crc(step_crc)
  );

  // narrow seed from low two bytes
  // wide seed uses all four bytes
  wire [31:0] seed_value = crc_width_select ? out_entry.word : {16'h0000, out_entry.word[15:0]};

  engine_state_type next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (fifo_out_valid) next_state = ST_FETCH;
      ST_FETCH: next_state = out_entry.seed ? ST_IDLE : ST_LATCH;
      ST_LATCH: next_state = ST_UPDATE;
      ST_UPDATE: next_state = (left == 3'd0) ? ST_IDLE : ST_LATCH;
      default: next_state = ST_IDLE;
    endcase
  end

  // Register writes
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= `CTRL_RESET;
      poly <= `POLY_RESET;
    end else begin
      if (ctrl_wr) ctrl <= ctrl_wdata & `CTRL_WRITABLE_MASK;
      if (poly_wr) begin
        poly[15:0] <= poly_wdata[15:0];
        // high half only writable in wide mode
        if (crc_width_select) poly[31:16] <= poly_wdata[31:16];
      end
    end
  end

  // Engine
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      crc <= `CRC_RESET;
      word_sh <= 32'h0000_0000;
      left <= 3'd0;
      cur_byte <= 8'h00;
    end else begin
      state <= next_state;
      unique case (state)
        ST_FETCH: begin
          if (out_entry.seed) crc <= seed_value;
          word_sh <= out_entry.word;
          left <= out_entry.nbytes;
        end
        ST_LATCH: begin
          cur_byte <= word_sh[31:24];
          word_sh <= {word_sh[23:0], 8'h00};
          left <= left - 3'd1;
        end
        // second clock folds it into the checksum
        ST_UPDATE: crc <= step_crc;
        default: ;
      endcase
    end
  end

  // Read side: every output comes from a flop
  // narrow result padded then transposed as 32 bits
  wire [31:0] crc_view = crc_width_select ? crc : {16'h0000, crc[15:0]};
  wire [31:0] rd_tr = transpose(crc_view, read_transpose_type);
  wire [31:0] rd_value = read_complement_enable ? ~rd_tr : rd_tr;
  wire [31:0] poly_view = crc_width_select ? poly : {16'h0000, poly[15:0]};

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      data_rdata <= 32'h0000_0000;
      ctrl_rdata <= `CTRL_RESET;
      poly_rdata <= `POLY_RESET;
      busy <= 1'b0;
    end else begin
      data_rdata <= rd_value;
      ctrl_rdata <= ctrl;
      poly_rdata <= poly_view;
      busy <= (next_state != ST_IDLE) || fifo_out_valid || data_wr;
    end
  end
endmodule // crc_engine_with_transpose
`default_nettype wire

// *** hdl/crc_fifo.sv ***
// Synchronous FIFO whose read word is registered at the pop
`timescale 1ns/1ns
`default_nettype none
module crc_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
    $error("crc_fifo needs a power of two depth of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic full;
  wire push = in_valid && !full;
  wire pop = out_ready && (count != '0);
  wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  assign in_ready = !full;
  assign out_valid = (count != '0);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      full <= 1'b0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      count <= next_count;
      full <= (next_count == (AW+1)'(DEPTH));
    end
  end

  // Storage carries no reset, so it maps onto plain RAM
  always_ff @(posedge mclk) begin
    if (push) mem[wr_ptr] <= in_data;
    if (pop) out_data <= mem[rd_ptr];
  end
endmodule // crc_fifo
`default_nettype wire

// *** verif/crc_engine_sva.sv ***
// Port checker for the CRC engine
`timescale 1ns/1ns
`default_nettype none
module crc_engine_sva (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ctrl_wr,
  input wire logic [31:0] ctrl_wdata,
  input wire logic [31:0] ctrl_rdata,
  input wire logic poly_wr,
  input wire logic [31:0] poly_wdata,
  input wire logic [31:0] poly_rdata,
  input wire logic data_wr,
  input wire logic data_ready,
  input wire logic [31:0] data_rdata,
  input wire logic busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic quiet;
  assign quiet = !ctrl_wr && !busy;
  ctrl_view_a:
    assert property (ctrl_wr |-> ##2 ctrl_rdata == ($past(ctrl_wdata, 2) & 32'hf700_0000))
    else $error("ctrl view");
  poly_low_a:
    assert property (poly_wr |-> ##2 poly_rdata[15:0] == $past(poly_wdata[15:0], 2))
    else $error("poly low");
  poly_narrow_a:
    assert property ((poly_wr && !ctrl_rdata[24] && !ctrl_wr && !$past(ctrl_wr)) ##1 !ctrl_wr
      |-> ##1 poly_rdata[31:16] == 16'h0000) else $error("poly high");
  busy_rise_a:
    assert property (data_wr && data_ready |=> busy) else $error("busy late");
  busy_end_a:
    assert property (data_wr && data_ready |-> ##[1:400] !busy) else $error("busy stuck");
  view_hold_a:
    assert property (quiet && $past(quiet) && $past(quiet, 2) |-> $stable(data_rdata))
    else $error("view moved");
  ready_fall_a:
    assert property ($fell(data_ready) |-> $past(data_wr)) else $error("ready fell");
  idle_ready_a:
    assert property (!busy |-> data_ready) else $error("idle not ready");
  cover property (data_wr && !data_ready);
  cover property ($fell(busy));
  cover property (poly_wr && ctrl_rdata[24]);
endmodule // crc_engine_sva
bind crc_engine_with_transpose crc_engine_sva crc_engine_sva_inst (.*);
`default_nettype wire

// *** verif/crc_engine_with_transpose_bench.sv ***
// Random self-checking bench for the CRC engine
`timescale 1ns/1ns
`default_nettype none
module crc_engine_with_transpose_bench
  import crc_engine_pkg::*;
;
  logic mclk, sys_rst, ctrl_wr, poly_wr, data_wr, data_ready, busy, ok;
  logic [1:0] data_size, sz;
  logic [31:0] ctrl_wdata, ctrl_rdata, poly_wdata, poly_rdata, data_wdata, data_rdata;
  logic [31:0] rnd, cfg, poly, crc, tw, view;
  int errors, samples_checked, nb;
  crc_engine_with_transpose #(.FIFO_DEPTH(16)) crc_engine_with_transpose_inst (.*);
  crc_sw_model crc_sw_model_inst (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    for (int i = 0; i < 32; i++) x = {x[30:0], ^(x & 32'h8020_0003)};
    return x;
  endfunction
  function automatic logic [31:0] trans(input logic [1:0] t, input logic [31:0] w);
    logic [31:0] r;
    for (int i = 0; i < 32; i++) r[i] = w[31 - i];
    if (t == TRANSPOSE_BITS) w = r;
    if (t[0]) w = {w[7:0], w[15:8], w[23:16], w[31:24]};
    return t == TRANSPOSE_BOTH ? r : w;
  endfunction
  // Narrow mode masks each step so upper bits never leak in
  function automatic logic [31:0] step(input logic [31:0] c, input logic [7:0] b,
    input logic [31:0] p, input logic wide);
    c ^= wide ? {b, 24'h0} : {16'h0, b, 8'h0};
    for (int i = 0; i < 8; i++) c = (wide ? c[31] : c[15]) ? (c << 1) ^ p : c << 1;
    return wide ? c : {16'h0, c[15:0]};
  endfunction
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic hung;
    check("wait", 32'h1, {31'h0, ok});
    if (ok !== 1'b1) give_verdict();
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    sys_rst = 1'b1;
    rnd = 32'h0000_9dcc;
    repeat (20) @(negedge mclk);
    sys_rst = 1'b0;
    for (int it = 0; it < 16; it++) begin
      rnd = lfsr(rnd);
      cfg = {it[1:0], it[3:2], rnd[27:0]} & 32'hfdff_ffff;
      poly = lfsr(rnd);
      rnd = lfsr(poly);
      crc_sw_model_inst.put_word(1'b0, cfg | 32'h0200_0000);
      crc_sw_model_inst.put_word(1'b1, poly);
      crc_sw_model_inst.put_data(2'h2, rnd, ok);
      hung();
      crc_sw_model_inst.rest();
      crc_sw_model_inst.put_word(1'b0, cfg);
      crc = trans(cfg[31:30], rnd) & (cfg[24] ? 32'hffff_ffff : 32'h0000_ffff);
      // Back-to-back writes overrun the queue on purpose
      for (int k = 0; k < 20; k++) begin
        rnd = lfsr(rnd);
        sz = rnd[5:4] == 2'h3 ? 2'h2 : rnd[5:4];
        nb = sz == 2'h2 ? 4 : sz + 1;
        crc_sw_model_inst.put_data(sz, rnd, ok);
        hung();
        tw = trans(cfg[31:30], rnd & (32'hffff_ffff >> (32 - 8 * nb)));
        for (int j = 0; j < nb; j++)
          crc = step(crc, cfg[31] ? tw[31 - 8 * j -: 8] : tw[8 * (nb - j) - 1 -: 8],
            poly, cfg[24]);
      end
      crc_sw_model_inst.rest();
      for (int n = 0; n < 1000 && busy !== 1'b0; n++) @(negedge mclk);
      ok = busy === 1'b0;
      hung();
      repeat (3) @(negedge mclk);
      view = trans(cfg[29:28], crc);
      check("view", cfg[26] ? ~view : view, data_rdata);
      crc_sw_model_inst.put_word(1'b0, cfg ^ 32'h0400_0000);
      repeat (2) @(negedge mclk);
      check("flipped", cfg[26] ? view : ~view, data_rdata);
      $display("test %0d done", it);
    end
    give_verdict();
  end
endmodule // crc_engine_with_transpose_bench
`default_nettype wire

// *** verif/crc_sw_model.sv ***
// Software side that writes the engine's ports
`timescale 1ns/1ns
`default_nettype none
module crc_sw_model (
  input wire logic mclk,
  input wire logic data_ready,
  output logic ctrl_wr,
  output logic [31:0] ctrl_wdata,
  output logic poly_wr,
  output logic [31:0] poly_wdata,
  output logic data_wr,
  output logic [1:0] data_size,
  output logic [31:0] data_wdata
);
  initial {ctrl_wr, poly_wr, data_wr, data_size, ctrl_wdata, poly_wdata, data_wdata} = '0;
  task automatic put_word(input logic is_poly, input logic [31:0] w);
    @(negedge mclk);
    {ctrl_wdata, poly_wdata} = {w, w};
    {ctrl_wr, poly_wr} = {!is_poly, is_poly};
    @(negedge mclk);
    {ctrl_wr, poly_wr} = 2'b00;
  endtask
  // whole units held until taken
  // Ready is read while settled, before the edge that takes the write
  task automatic put_data(input logic [1:0] sz, input logic [31:0] w, output logic ok);
    @(negedge mclk);
    {data_wr, data_size, data_wdata} = {1'b1, sz, w};
    ok = 1'b0;
    for (int n = 0; n < 400 && !ok; n++) begin
      ok = data_ready;
      @(posedge mclk);
      if (!ok) @(negedge mclk);
    end
  endtask
  // Released data no longer shows the old word
  task automatic rest;
    @(negedge mclk);
    data_wr = 1'b0;
    data_wdata = ~data_wdata;
  endtask
endmodule // crc_sw_model
`default_nettype wire
